// >>> hdl/idc_dma.sv
`timescale 1ns/100ps
`include "idc_defs.svh"

// Operation
// - seven channels: 0-3 first controller, 5-7 second; 4 is cascade.
// - writing one to a request bit starts service like a hardware request.
// - channels 0-3 move bytes and count once per byte.
// - channels 5-7 move words, count per word, address shifted left one.
// - address is page register bits above the 16-bit current address.
// - refresh addresses generated; autoinit reloads after termination.
// - master serves slaves or cascaded masters; slave takes writes.
// - memory strobes driven during DMA when address is below 16 Mbytes.
// - low-memory strobes driven only when address is below 1 Mbyte.
// - memory strobes suppressed at or above 16 Mbytes to avoid aliasing.
// - AEN and BALE held high throughout DMA cycles.
// - a raised request asserts the PCI hold request.
// - acknowledge stays negated until hold grant is sampled asserted.
// - each transfer counts down, steps address; TC on zero rollover.
// - cascade mode answers with acknowledge and BALE only; strobes, address undriven.
// - compatible hardware requests wait eight SYSCLKs; not sw or fast.
// - fast timing only with increment and single or demand mode.
module idc_dma import idc_pkg::*; #(
  parameter int SYSCLK_DIV = `IDC_SYSCLK_DIV,
  parameter int DATA_W = 16
) (
  input wire logic SYS_CLK, // 25 MHz system clock
  input wire logic RST_N, // synchronous reset, active low
  input wire logic [7:0] DREQ, // request pins, asynchronous
  input wire logic PCI_HOLD_GRANT_N, // hold grant pin, active low
  input wire logic [DATA_W-1:0] ISA_DATA, // I/O device data pins
  input wire logic REFRESH_REQ, // refresh tick, one cycle
  input wire logic CFG_WE, // program one channel
  input wire logic [2:0] CFG_CH, // channel being programmed
  input wire logic [15:0] CFG_ADDR, // base address
  input wire logic [15:0] CFG_COUNT, // base count minus one
  input wire logic [7:0] CFG_PAGE, // page register
  input wire logic [2:0] CFG_PAGE_HI, // address bits above 16 Mbytes
  input wire logic [1:0] CFG_MODE, // channel_mode_register mode field
  input wire logic CFG_AUTOINIT, // reload after terminal count
  input wire logic CFG_DECREMENT, // step address downward
  input wire logic CFG_TO_MEMORY, // I/O to memory transfer
  input wire logic SW_REQ_WE, // request register write
  input wire logic [7:0] SW_REQ, // ones start requests
  input wire logic [7:0] ONBOARD_CHANNEL_FAST_ENABLE, // fast timing per channel
  input wire logic MEM_DATA_READY, // memory side takes a word
  output logic PCI_HOLD_REQUEST_N, // hold request, active low
  output logic [7:0] DACK_N, // acknowledges, active low
  output logic [23:0] MEM_ADDR, // bus address
  output logic MEMR_N, // memory read strobe
  output logic MEMW_N, // memory write strobe
  output logic SMEMR_N, // low-memory read strobe
  output logic SMEMW_N, // low-memory write strobe
  output logic IOR_N, // I/O read strobe
  output logic IOW_N, // I/O write strobe
  output logic CMD_OE, // command strobes driven
  output logic ADDR_OE, // address lines driven
  output logic AEN, // address enable
  output logic BALE, // address latch enable
  output logic TC, // terminal count, one cycle
  output logic [7:0] REFRESH_ADDR, // refresh row address
  output logic [7:0] SW_REQ_STATUS, // pending software requests
  output logic MEM_DATA_VALID, // word for memory present
  output logic [DATA_W-1:0] MEM_DATA // word for memory
);
  localparam logic [7:0] DLY_CYC = 8'(`IDC_DREQ_DLY_SYSCLK * SYSCLK_DIV);
  localparam logic [7:0] COMPAT_CYC = 8'(`IDC_COMPAT_SYSCLK * SYSCLK_DIV);
  localparam logic [7:0] FAST_CYC = 8'(`IDC_FAST_SYSCLK * SYSCLK_DIV);

  if (SYSCLK_DIV < 1 || `IDC_COMPAT_SYSCLK * SYSCLK_DIV > 255 ||
      (DATA_W != 8 && DATA_W != 16)) begin : g_chk
    $error("idc_dma: SYSCLK_DIV or DATA_W out of range");
  end

  // lowest set request of a four-channel group
  function automatic logic [1:0] pick4(input logic [3:0] r);
    pick4 = r[0] ? 2'h0 : r[1] ? 2'h1 : r[2] ? 2'h2 : 2'h3;
  endfunction

  logic [7:0] dreq_m_r, dreq_s_r;
  logic grant_m_r, grant_s_r;
  logic [DATA_W-1:0] data_m_r, data_s_r;
  logic [15:0] base_addr_r [8];
  logic [15:0] base_cnt_r [8];
  logic [15:0] cur_addr_r [8];
  logic [15:0] cur_cnt_r [8];
  logic [7:0] page_r [8];
  logic [2:0] hi_r [8];
  idc_mode_t mode_r [8];
  logic [7:0] auto_r, dec_r, tomem_r;
  logic [7:0] dly_r [8];
  logic [7:0] sw_req_r, sw_req_nxt;
  idc_state_t st_r, st_nxt;
  logic [2:0] sel_r;
  logic [7:0] cyc_r;
  logic [26:0] bus_addr_r;
  logic [7:0] refresh_r;
  logic [7:0] fast_ok, dly_done, eff_req, raw_req, clr_mask;
  logic [3:0] req1, req2;
  logic [1:0] w1, w2;
  logic [2:0] win;
  logic any_req, in_x, in_c, own, wide, cnt_zero, step, buf_rdy;
  logic [7:0] period;
  logic [26:0] bus_addr;
  logic below16, below1m;

  // two-flop synchronisers on the request, grant and I/O data pins
  always_ff @(posedge SYS_CLK) begin
    dreq_m_r <= DREQ;
    dreq_s_r <= dreq_m_r;
    grant_m_r <= PCI_HOLD_GRANT_N;
    grant_s_r <= grant_m_r;
    data_m_r <= ISA_DATA;
    data_s_r <= data_m_r;
  end

  // fast timing qualification
  // a fast bit on a decrementing or block channel falls back to compatible
  assign fast_ok[3:0] = ONBOARD_CHANNEL_FAST_ENABLE[3:0] & ~dec_r[3:0];
  assign fast_ok[7:4] = ONBOARD_CHANNEL_FAST_ENABLE[7:4] & ~dec_r[7:4];
  assign raw_req = dreq_s_r | sw_req_r;

  genvar gc;
  for (gc = 0; gc < 8; gc++) begin : g_ch
    logic fast_mode;
    assign fast_mode = fast_ok[gc] && mode_r[gc] != MD_BLOCK &&
                       mode_r[gc] != MD_CASCADE;
    assign dly_done[gc] = dly_r[gc] == DLY_CYC;
    assign eff_req[gc] = sw_req_r[gc] ||
                         (dreq_s_r[gc] && (fast_mode || dly_done[gc]));
    always_ff @(posedge SYS_CLK) begin
      if (!RST_N || !dreq_s_r[gc]) begin
        dly_r[gc] <= 8'h00;
      end else if (!dly_done[gc]) begin
        dly_r[gc] <= dly_r[gc] + 8'h01;
      end
    end
  end

  // first controller cascades into channel 4
  assign req1 = eff_req[3:0];
  assign req2 = {eff_req[7:5], |req1};
  assign w1 = pick4(req1);
  assign w2 = pick4(req2);
  assign win = (w2 == 2'h0) ? {1'b0, w1} : {1'b1, w2};
  assign any_req = |req2;

  assign in_x = st_r == ST_XFER;
  assign in_c = st_r == ST_CASC;
  assign own = in_x || in_c;
  assign wide = sel_r >= `IDC_WIDE_CH;
  assign cnt_zero = cur_cnt_r[sel_r] == 16'h0000;
  assign period = (fast_ok[sel_r] && mode_r[sel_r] != MD_BLOCK) ?
                  FAST_CYC : COMPAT_CYC;
  // a full buffer stalls the transfer rather than dropping a word
  assign step = in_x && cyc_r == period - 8'h01 &&
                (buf_rdy || !tomem_r[sel_r]);

  // wide channels drive the word address shifted left
  assign bus_addr = wide ?
    {hi_r[sel_r], page_r[sel_r][7:1], cur_addr_r[sel_r], 1'b0} :
    {hi_r[sel_r], page_r[sel_r], cur_addr_r[sel_r]};
  // no memory strobes at or above 16 Mbytes
  assign below16 = bus_addr[26:`IDC_ISAMEM_BIT] == 3'h0;
  assign below1m = bus_addr[26:`IDC_LOWMEM_BIT] == 7'h00;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        // request raises hold
        // a stale grant from the last service must drop before a new hold
        if (any_req && grant_s_r) begin
          st_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!grant_s_r) begin
          // cascade gives the bus away with acknowledge and BALE only
          st_nxt = (mode_r[sel_r] == MD_CASCADE) ? ST_CASC : ST_XFER;
        end
      end
      ST_XFER: begin
        if (step && (cnt_zero || mode_r[sel_r] == MD_SINGLE ||
            (mode_r[sel_r] == MD_DEMAND && !raw_req[sel_r]))) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_CASC: begin
        if (!raw_req[sel_r]) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // request register; a write that meets the clear still sets
  assign clr_mask = (step && cnt_zero) ? (8'h01 << sel_r) : 8'h00;
  assign sw_req_nxt = ((sw_req_r & ~clr_mask) | (SW_REQ_WE ? SW_REQ : 8'h00))
                      & `IDC_SWREQ_MASK;

  // sequencer flops
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_r <= ST_IDLE;
      sel_r <= 3'h0;
      cyc_r <= 8'h00;
      sw_req_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      sw_req_r <= sw_req_nxt;
      if (st_r == ST_IDLE) begin
        sel_r <= win;
      end
      cyc_r <= (!in_x || step) ? 8'h00 :
               (cyc_r == period - 8'h01) ? cyc_r : cyc_r + 8'h01;
    end
  end

  // channel registers: slave-side programming and per-transfer stepping
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      auto_r <= 8'h00;
      dec_r <= 8'h00;
      tomem_r <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        base_addr_r[i] <= 16'h0000;
        base_cnt_r[i] <= 16'h0000;
        cur_addr_r[i] <= 16'h0000;
        cur_cnt_r[i] <= 16'h0000;
        page_r[i] <= 8'h00;
        hi_r[i] <= 3'h0;
        // channel 4 comes out of reset in cascade mode
        mode_r[i] <= (3'(i) == `IDC_CASC_CH) ? MD_CASCADE : MD_SINGLE;
      end
    end else begin
      // count down, step address, reload on rollover
      if (step) begin
        if (cnt_zero && auto_r[sel_r]) begin
          cur_addr_r[sel_r] <= base_addr_r[sel_r];
          cur_cnt_r[sel_r] <= base_cnt_r[sel_r];
        end else begin
          // one count per byte or word
          cur_cnt_r[sel_r] <= cur_cnt_r[sel_r] - 16'h0001;
          cur_addr_r[sel_r] <= dec_r[sel_r] ?
            cur_addr_r[sel_r] - 16'h0001 : cur_addr_r[sel_r] + 16'h0001;
        end
      end
      // slave mode register writes; programming wins over a step
      if (CFG_WE) begin
        base_addr_r[CFG_CH] <= CFG_ADDR;
        base_cnt_r[CFG_CH] <= CFG_COUNT;
        cur_addr_r[CFG_CH] <= CFG_ADDR;
        cur_cnt_r[CFG_CH] <= CFG_COUNT;
        page_r[CFG_CH] <= CFG_PAGE;
        hi_r[CFG_CH] <= CFG_PAGE_HI;
        auto_r[CFG_CH] <= CFG_AUTOINIT;
        dec_r[CFG_CH] <= CFG_DECREMENT;
        tomem_r[CFG_CH] <= CFG_TO_MEMORY;
        // the cascade channel keeps its mode
        if (CFG_CH != `IDC_CASC_CH) begin
          mode_r[CFG_CH] <= idc_mode_t'(CFG_MODE);
        end
      end
    end
  end

  // bus pins, all registered
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      PCI_HOLD_REQUEST_N <= 1'b1;
      DACK_N <= 8'hff;
      bus_addr_r <= 27'h0;
      MEMR_N <= 1'b1;
      MEMW_N <= 1'b1;
      SMEMR_N <= 1'b1;
      SMEMW_N <= 1'b1;
      IOR_N <= 1'b1;
      IOW_N <= 1'b1;
      CMD_OE <= 1'b0;
      ADDR_OE <= 1'b0;
      AEN <= 1'b0;
      BALE <= 1'b0;
      TC <= 1'b0;
    end else begin
      // hold asserted whenever the sequencer's next state is not idle
      PCI_HOLD_REQUEST_N <= st_nxt == ST_IDLE;
      // acknowledge only once the bus is owned
      DACK_N <= own ? ~(8'h01 << sel_r) : 8'hff;
      bus_addr_r <= bus_addr;
      // memory strobes below 16 Mbytes, PCI or ISA alike
      MEMR_N <= !(in_x && !tomem_r[sel_r] && below16);
      MEMW_N <= !(in_x && tomem_r[sel_r] && below16);
      SMEMR_N <= !(in_x && !tomem_r[sel_r] && below1m);
      SMEMW_N <= !(in_x && tomem_r[sel_r] && below1m);
      IOR_N <= !(in_x && tomem_r[sel_r]);
      IOW_N <= !(in_x && !tomem_r[sel_r]);
      // cascade leaves commands and address floating
      CMD_OE <= in_x;
      ADDR_OE <= in_x;
      // AEN high for DMA cycles, low for a cascaded master
      AEN <= in_x;
      BALE <= own;
      TC <= step && cnt_zero;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      refresh_r <= 8'h00;
    end else if (REFRESH_REQ) begin
      refresh_r <= refresh_r + 8'h01;
    end
  end

  assign MEM_ADDR = bus_addr_r[23:0];
  assign REFRESH_ADDR = refresh_r;
  assign SW_REQ_STATUS = sw_req_r;

  // captured I/O data heads for memory through the two-entry buffer
  idc_buf2 #(.WIDTH(DATA_W)) u_buf (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .in_valid(step && tomem_r[sel_r]),
    .in_data(data_s_r),
    .in_ready(buf_rdy),
    .out_valid(MEM_DATA_VALID),
    .out_data(MEM_DATA),
    .out_ready(MEM_DATA_READY)
  );

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  chk_casc_mode_fixed: assert property (mode_r[4] == MD_CASCADE)
    else $error("cascade channel left cascade mode");
  chk_sw_req_set: assert property (
    SW_REQ_WE |=> (sw_req_r & $past(SW_REQ) & `IDC_SWREQ_MASK) ==
                  ($past(SW_REQ) & `IDC_SWREQ_MASK))
    else $error("software request bit lost");
  chk_hold_on_req: assert property (
    (st_r == ST_IDLE && any_req && grant_s_r) |=> !PCI_HOLD_REQUEST_N)
    else $error("hold not requested");
  chk_dack_no_grant: assert property (
    (st_r == ST_HOLD && grant_s_r) |=> DACK_N == 8'hff ##1 DACK_N == 8'hff)
    else $error("acknowledge before grant");
  chk_strobe_16m: assert property (
    (!MEMR_N || !MEMW_N) |-> bus_addr_r[26:24] == 3'h0 && AEN)
    else $error("memory strobe at or above 16 Mbytes");
  chk_smem_1m: assert property (
    (!SMEMR_N || !SMEMW_N) |-> bus_addr_r[26:20] == 7'h00)
    else $error("low-memory strobe above 1 Mbyte");
  chk_aen_bale: assert property (CMD_OE |-> AEN && BALE)
    else $error("AEN or BALE low in DMA cycle");
  chk_casc_quiet: assert property (
    in_c |=> !CMD_OE && !ADDR_OE && !AEN)
    else $error("cascade drove the bus");
  chk_dreq_delay: assert property (
    ($rose(dreq_s_r[0]) && !fast_ok[0] && !sw_req_r[0]) |->
      !eff_req[0] [*8])
    else $error("request not delayed");
  chk_tc_wrap: assert property (
    (step && cnt_zero && !auto_r[sel_r]) |=>
      TC && cur_cnt_r[sel_r] == 16'hffff)
    else $error("terminal count wrong");
  chk_word_addr: assert property ((in_x && wide) |=> !MEM_ADDR[0])
    else $error("word channel address not shifted");
endmodule // idc_dma

// >>> hdl/idc_defs.svh
`ifndef IDC_DEFS_SVH
`define IDC_DEFS_SVH

// link clock to ISA SYSCLK ratio
`define IDC_SYSCLK_DIV 4
// request delay in compatible timing, in SYSCLK periods
`define IDC_DREQ_DLY_SYSCLK 8
// transfer repetition rates, in SYSCLK periods
`define IDC_COMPAT_SYSCLK 8
`define IDC_FAST_SYSCLK 3
// address bit positions for the 1 Mbyte and 16 Mbyte limits
`define IDC_LOWMEM_BIT 20
`define IDC_ISAMEM_BIT 24
// channel that joins the two controllers
`define IDC_CASC_CH 3'h4
// first channel of the second controller
`define IDC_WIDE_CH 3'h5
// software request bits that can exist (no bit for the cascade channel)
`define IDC_SWREQ_MASK 8'hef

`endif

// >>> hdl/idc_pkg.sv
package idc_pkg;
  // transfer modes per channel, in the mode register's encoding
  typedef enum logic [1:0] {
    MD_DEMAND = 2'h0,
    MD_SINGLE = 2'h1,
    MD_BLOCK = 2'h2,
    MD_CASCADE = 2'h3
  } idc_mode_t;
  // service sequencer
  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_XFER, ST_CASC} idc_state_t;
endpackage

// >>> hdl/idc_buf2.sv
`timescale 1ns/100ps
module idc_buf2 #(
  parameter int WIDTH = 16
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic in_valid, // word offered
  input wire logic [WIDTH-1:0] in_data, // word offered
  output logic in_ready, // room for a word
  output logic out_valid, // head word present
  output logic [WIDTH-1:0] out_data, // head word
  input wire logic out_ready // sink takes the head word
);
  logic v0_r, v1_r, v0_nxt, v1_nxt;
  logic [WIDTH-1:0] d0_r, d1_r, d0_nxt, d1_nxt;
  logic push, pop;

  if (WIDTH < 1) begin : g_chk
    $error("idc_buf2: WIDTH must be at least 1");
  end

  // both flags are flops, so ready and valid never loop combinationally
  assign in_ready = !v1_r;
  assign out_valid = v0_r;
  assign out_data = d0_r;
  assign push = in_valid && !v1_r;
  assign pop = v0_r && out_ready;

  // head always sits in entry 0; a pop shifts entry 1 forward
  always_comb begin
    v0_nxt = v0_r;
    v1_nxt = v1_r;
    d0_nxt = d0_r;
    d1_nxt = d1_r;
    if (pop) begin
      v0_nxt = v1_r;
      d0_nxt = d1_r;
      v1_nxt = 1'b0;
    end
    if (push) begin
      if (!v0_nxt) begin
        v0_nxt = 1'b1;
        d0_nxt = in_data;
      end else begin
        v1_nxt = 1'b1;
        d1_nxt = in_data;
      end
    end
  end

  // storage flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      v0_r <= 1'b0;
      v1_r <= 1'b0;
      d0_r <= '0;
      d1_r <= '0;
    end else begin
      v0_r <= v0_nxt;
      v1_r <= v1_nxt;
      d0_r <= d0_nxt;
      d1_r <= d1_nxt;
    end
  end
endmodule // idc_buf2

// >>> verification/idc_far_side.sv
`timescale 1ns/100ps
// hold arbiter and I/O device as seen from the block's pins
module idc_far_side (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic hold_n, // hold request, active low
  input wire logic [7:0] dack_n, // acknowledges, active low
  input wire logic [3:0] gnt_dly, // cycles before the grant
  output logic grant_n, // hold grant, active low
  output logic [15:0] word // I/O device data
);
  logic [3:0] wait_r;
  logic [15:0] next_r;
  logic [15:0] junk_r;
  logic ack_r;
  logic ack;
  // device drives its word only while acknowledged; a moving pattern
  // otherwise, so an early or late capture cannot match by chance
  assign ack = (dack_n != 8'hff);
  assign word = ack ? next_r : junk_r;
  // grant after wait
  // the wait stands for bus and memory becoming free together
  always_ff @(posedge clk) begin
    if (!rst_n || hold_n) begin
      grant_n <= 1'b1;
      wait_r <= 4'h0;
    end else if (wait_r >= gnt_dly) begin
      grant_n <= 1'b0;
    end else begin
      wait_r <= wait_r + 4'h1;
    end
  end
  // next word advances once per finished service
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      next_r <= 16'ha500;
      junk_r <= 16'h5a5a;
      ack_r <= 1'b0;
    end else begin
      next_r <= (ack_r && !ack) ? next_r + 16'h1 : next_r;
      junk_r <= ~junk_r + 16'h3;
      ack_r <= ack;
    end
  end
endmodule // idc_far_side

// >>> verification/idc_dma_bench.sv
`timescale 1ns/100ps
module idc_dma_bench;
  import idc_pkg::*;
  logic clk = 1'b0;
  logic rst_n, grant_n, ref_req, cfg_we, sw_we, ready;
  logic [7:0] dreq, sw_req, fast, cfg_page;
  logic [2:0] cfg_ch, cfg_hi, cfg_flags;
  logic [1:0] cfg_mode;
  logic [15:0] cfg_addr, cfg_count, isa_word;
  logic [3:0] gnt_dly;
  wire hold_n, tc, aen, bale, cmd_oe, addr_oe, mem_valid;
  wire [5:0] strb;
  wire [7:0] dack_n, ref_addr, sw_status;
  wire [15:0] mem_data;
  wire [23:0] mem_addr;
  logic [23:0] seen_a[$];
  int tcs;
  int err_count = 0;
  int compares = 0;

  // divider of 2 keeps every period short but distinct
  idc_dma #(.SYSCLK_DIV(2), .DATA_W(16)) dut (
    .SYS_CLK(clk), .RST_N(rst_n), .DREQ(dreq),
    .PCI_HOLD_GRANT_N(grant_n), .ISA_DATA(isa_word),
    .REFRESH_REQ(ref_req), .CFG_WE(cfg_we), .CFG_CH(cfg_ch),
    .CFG_ADDR(cfg_addr), .CFG_COUNT(cfg_count), .CFG_PAGE(cfg_page),
    .CFG_PAGE_HI(cfg_hi), .CFG_MODE(cfg_mode),
    .CFG_AUTOINIT(cfg_flags[2]), .CFG_DECREMENT(cfg_flags[1]),
    .CFG_TO_MEMORY(cfg_flags[0]), .SW_REQ_WE(sw_we), .SW_REQ(sw_req),
    .ONBOARD_CHANNEL_FAST_ENABLE(fast), .MEM_DATA_READY(ready),
    .PCI_HOLD_REQUEST_N(hold_n), .DACK_N(dack_n), .MEM_ADDR(mem_addr),
    .MEMR_N(strb[5]), .MEMW_N(strb[4]), .SMEMR_N(strb[3]),
    .SMEMW_N(strb[2]), .IOR_N(strb[1]), .IOW_N(strb[0]),
    .CMD_OE(cmd_oe), .ADDR_OE(addr_oe), .AEN(aen), .BALE(bale), .TC(tc),
    .REFRESH_ADDR(ref_addr), .SW_REQ_STATUS(sw_status),
    .MEM_DATA_VALID(mem_valid), .MEM_DATA(mem_data)
  );
  idc_far_side far (.clk(clk), .rst_n(rst_n), .hold_n(hold_n),
    .dack_n(dack_n), .gnt_dly(gnt_dly), .grant_n(grant_n), .word(isa_word));

  // 25 MHz
  always #20 clk = ~clk;

  // inputs move 1 ns after the edge, away from sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic give_up(input string what);
    err_count++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    tally_and_finish();
  endtask
  // all channel fields in one write; fl is {autoinit, decrement, to_memory}
  task automatic cfg(input logic [2:0] ch, input logic [1:0] md,
      input logic [2:0] hi, input logic [7:0] pg, input logic [15:0] a,
      input logic [15:0] c, input logic [2:0] fl);
    {cfg_ch, cfg_mode, cfg_hi, cfg_page} = {ch, md, hi, pg};
    {cfg_addr, cfg_count, cfg_flags} = {a, c, fl};
    cfg_we = 1'b1;
    step(1);
    cfg_we = 1'b0;
  endtask
  task automatic swreq(input logic [7:0] bits);
    sw_req = bits;
    sw_we = 1'b1;
    step(1);
    sw_we = 1'b0;
  endtask
  // counts cycles of grant seen low before the acknowledge shows
  task automatic wait_ack(input logic [7:0] exp);
    int n;
    int g;
    n = 0;
    g = 0;
    while (dack_n === 8'hff) begin
      g = (grant_n === 1'b0) ? g + 1 : 0;
      n++;
      if (n > 300) give_up("ack");
      step(1);
    end
    check("grant before ack", 32'(g >= 2), 32'h1);
    check("hold at ack", 32'(hold_n), 32'h0);
    check("ack", 32'(dack_n), 32'(exp));
  endtask
  // follows one service: bus addresses while strobes are driven, and TC
  task automatic collect;
    int n;
    n = 0;
    tcs = 0;
    seen_a.delete();
    while (dack_n !== 8'hff) begin
      if (cmd_oe === 1'b1 && (seen_a.size() == 0 || seen_a[$] !== mem_addr))
        seen_a.push_back(mem_addr);
      if (tc === 1'b1) tcs++;
      n++;
      if (n > 500) give_up("release");
      step(1);
    end
    if (tc === 1'b1) tcs++;
    step(1);
    if (tc === 1'b1) tcs++;
  endtask
  // software-requested service with its expected bus view
  task automatic svc(input logic [2:0] ch, input logic [23:0] a0,
      input logic [5:0] st, input int n, input logic [23:0] last);
    swreq(8'h01 << ch);
    check("sw status", 32'(sw_status), 32'(8'h01 << ch));
    wait_ack(~(8'h01 << ch));
    check("addr", 32'(mem_addr), 32'(a0));
    check("strobes", 32'(strb), 32'(st));
    check("aen bale oe", 32'({aen, bale, cmd_oe, addr_oe}), 32'hf);
    collect();
    check("steps", 32'(seen_a.size()), 32'(n));
    check("last addr", 32'(seen_a[$]), 32'(last));
    check("tc", 32'(tcs), 32'h1);
  endtask
  // hardware request: exp is hold still high seven cycles on
  task automatic hw(input logic [2:0] ch, input logic exp);
    dreq[ch] = 1'b1;
    step(7);
    check("early hold", 32'(hold_n), 32'(exp));
    wait_ack(~(8'h01 << ch));
    dreq[ch] = 1'b0;
    collect();
    check("hw tc", 32'(tcs), 32'h1);
  endtask

  initial begin
    int got;
    {dreq, ref_req, cfg_we, sw_we, sw_req, fast} = '0;
    {cfg_ch, cfg_mode, cfg_hi, cfg_page, cfg_addr, cfg_count, cfg_flags} = '0;
    {rst_n, ready, gnt_dly} = {1'b0, 1'b0, 4'h1};
    step(8);
    rst_n = 1'b1;
    step(1);
    check("reset pins", 32'({hold_n, dack_n, strb, aen, tc, mem_valid,
      ref_addr}), 32'({1'b1, 8'hff, 6'h3f, 3'h0, 8'h0}));
    // refresh row advances once per tick
    repeat (3) begin
      ref_req = 1'b1;
      step(1);
      ref_req = 1'b0;
      step(1);
    end
    check("refresh", 32'(ref_addr), 32'h3);
    // the joining channel takes no request of its own
    swreq(8'h10);
    dreq[4] = 1'b1;
    step(30);
    check("ch4 ignored", 32'({sw_status, hold_n}), 32'h1);
    dreq[4] = 1'b0;
    // fast writes with autoinit while memory stalls
    fast = 8'h02;
    cfg(3'h1, MD_SINGLE, 3'h0, 8'h12, 16'h3456, 16'h0, 3'b101);
    svc(3'h1, 24'h123456, 6'b101101, 1, 24'h123456);
    svc(3'h1, 24'h123456, 6'b101101, 1, 24'h123456);
    swreq(8'h02);
    wait_ack(8'hfd);
    step(20);
    check("stall", 32'({dack_n, mem_valid}), 32'({8'hfd, 1'b1}));
    ready = 1'b1;
    got = 0;
    for (int i = 0; i < 80 && got < 3; i++) begin
      if (mem_valid === 1'b1) begin
        check("word", 32'(mem_data), 32'(16'ha500 + got));
        got++;
      end
      step(1);
    end
    collect();
    check("drained", 32'({got[1:0], mem_valid}), 32'h6);
    // compatible singles over the address ranges, then block stepping
    {fast, gnt_dly} = {8'h00, 4'h9};
    cfg(3'h5, MD_SINGLE, 3'h0, 8'h34, 16'h1234, 16'h0, 3'b000);
    svc(3'h5, 24'h342468, 6'b011110, 1, 24'h342468);
    cfg(3'h3, MD_SINGLE, 3'h0, 8'h0f, 16'hfffe, 16'h0, 3'b001);
    svc(3'h3, 24'h0ffffe, 6'b101001, 1, 24'h0ffffe);
    cfg(3'h7, MD_SINGLE, 3'h0, 8'h10, 16'h0000, 16'h0, 3'b000);
    svc(3'h7, 24'h100000, 6'b011110, 1, 24'h100000);
    cfg(3'h6, MD_SINGLE, 3'h0, 8'hff, 16'hffff, 16'h0, 3'b001);
    svc(3'h6, 24'hfffffe, 6'b101101, 1, 24'hfffffe);
    cfg(3'h2, MD_SINGLE, 3'h1, 8'h00, 16'h0010, 16'h0, 3'b000);
    svc(3'h2, 24'h000010, 6'b111110, 1, 24'h000010);
    cfg(3'h5, MD_BLOCK, 3'h0, 8'h00, 16'h0100, 16'h2, 3'b001);
    svc(3'h5, 24'h000200, 6'b101001, 3, 24'h000204);
    cfg(3'h0, MD_BLOCK, 3'h0, 8'h02, 16'h0001, 16'h1, 3'b011);
    svc(3'h0, 24'h020001, 6'b101001, 2, 24'h020000);
    // hardware requests: compatible, fast, fast on decrement, fast on block
    {fast, gnt_dly} = {8'h01, 4'h1};
    cfg(3'h1, MD_SINGLE, 3'h0, 8'h20, 16'h0, 16'h0, 3'b000);
    hw(3'h1, 1'b1);
    cfg(3'h0, MD_SINGLE, 3'h0, 8'h20, 16'h0, 16'h0, 3'b000);
    hw(3'h0, 1'b0);
    cfg(3'h0, MD_SINGLE, 3'h0, 8'h20, 16'h8, 16'h0, 3'b010);
    hw(3'h0, 1'b1);
    cfg(3'h0, MD_BLOCK, 3'h0, 8'h20, 16'h0, 16'h0, 3'b000);
    hw(3'h0, 1'b1);
    // demand service ends at the first step after the request drops
    cfg(3'h0, MD_DEMAND, 3'h0, 8'h30, 16'h10, 16'h3, 3'b000);
    dreq[0] = 1'b1;
    wait_ack(8'hfe);
    dreq[0] = 1'b0;
    collect();
    check("demand", 32'({16'(seen_a.size()), 16'(tcs)}), 32'h10000);
    // a bus master on a word channel gets the acknowledge and BALE, nothing else
    cfg(3'h7, MD_CASCADE, 3'h0, 8'h00, 16'h0, 16'h0, 3'b000);
    dreq[7] = 1'b1;
    wait_ack(8'h7f);
    step(10);
    check("cascade pins", 32'({dack_n, strb, aen, bale, cmd_oe, addr_oe}),
      32'({8'h7f, 6'h3f, 4'h4}));
    dreq[7] = 1'b0;
    collect();
    check("cascade quiet", 32'({16'(seen_a.size()), 16'(tcs)}), 32'h0);
    tally_and_finish();
  end
endmodule // idc_dma_bench
